// ==== src/ucs_pkg.sv ====
// Purpose: Shared constants for the charger status and measurement register block
// Assumes: 8-bit registers addressed by an 8-bit register index on the serial link
// Notes: Offsets match the device register map; config bit offsets are local
package ucs_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] SETUP3_OFS = 8'h03;
  localparam logic [7:0] SAMPLE_REQ_OFS = 8'h05;
  localparam logic [7:0] MASK0_OFS = 8'h07;
  localparam logic [7:0] MASK2_OFS = 8'h09;
  localparam logic [7:0] EVENT_FLAGS_OFS = 8'h0A;
  localparam logic [7:0] FAULT_FLAGS_OFS = 8'h0C;
  localparam logic [7:0] ATTACH_STATUS_OFS = 8'h0D;
  localparam logic [7:0] LOAD_CURRENT_OFS = 8'h10;
  localparam logic [7:0] PORT_VOLTAGE_OFS = 8'h11;
  localparam logic [7:0] DIE_TEMP_OFS = 8'h12;
  localparam logic [7:0] CONFIG_SRC_OFS = 8'h13;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int THERMAL_BIT = 3;
  localparam int INPUT_OV_BIT = 2;
  localparam int DATAPIN_OV_BIT = 1;
  localparam int ATTACH_BIT = 3;
  localparam int AUTO_CLEAR_BIT = 7;
  localparam int SAMPLE_DONE_BIT = 0;
  localparam int MODE_LSB = 4;

  // ****************************************
  // Reset values and constants
  // ****************************************
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [2:0] FAULT_MASK = 3'h7;
  localparam logic [7:0] FAULT_BITS = 8'h0E;
  localparam logic [7:0] MASK0_BITS = 8'h8B;
  // Thermal warning threshold 140 C as a code: (140 + 270) / 3.5 rounded up
  localparam logic [7:0] THERMAL_WARN_CODE = 8'h76;

  // Charger mode encodings
  typedef enum logic [1:0] {
    UCS_MODE_PASS = 2'b00,
    UCS_MODE_CDP = 2'b01,
    UCS_MODE_DCP_HI = 2'b10,
    UCS_MODE_DCP_LO = 2'b11
  } ucs_mode_t;

  // Sample sequencer states, Gray coded from IDLE through CONV to LOAD; LOAD back to IDLE flips both bits
  typedef enum logic [1:0] {
    UCS_S_IDLE = 2'b00,
    UCS_S_CONV = 2'b01,
    UCS_S_LOAD = 2'b11
  } ucs_state_t;

endpackage

// ==== src/ucs_flag.sv ====
// Purpose: One read-clear fault flag with sticky or auto-clear behaviour
// Assumes: Condition input is synchronous to mclk_i
// Notes: A set in the read cycle wins over the clear
`timescale 1ns/1ns
module ucs_flag (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic cond_i,
  input wire logic read_i,
  input wire logic auto_clear_i,
  output logic flag_o
);
  logic flag_reg;
  logic flag_next;

  always_comb begin
    flag_next = flag_reg;
    if (cond_i) begin
      flag_next = 1'b1;
    end else if (read_i || auto_clear_i) begin
      flag_next = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_o = flag_reg;
endmodule

// ==== src/ucs_regs.sv ====
// Purpose: Fault flags, live status, measurement results and config sources
// Assumes: Register port is a byte-wide strobe interface from the serial link slave
// Notes: Reads return data one cycle after rd_i; irq_o ORs the masked fault flags and events
`timescale 1ns/1ns
module ucs_regs (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic input_ov_i,
  input wire logic datapin_ov_i,
  input wire logic attach_i,
  input wire logic enum_start_i,
  input wire logic data_mode_pin_i,
  input wire logic standalone_i,
  input wire logic [7:0] first_config_resistor_i,
  input wire logic [7:0] second_config_resistor_i,
  input wire logic [7:0] third_config_resistor_i,
  input wire logic conv_done_i,
  input wire logic [7:0] load_current_code_i,
  input wire logic [7:0] port_voltage_code_i,
  input wire logic [7:0] die_temp_code_i,
  output logic conv_start_o,
  output logic irq_o,
  output logic [1:0] charger_mode_o,
  output logic spread_spectrum_o,
  output logic sync_is_output_o,
  output logic [2:0] freq_select_o,
  output logic [2:0] current_limit_o,
  output logic [4:0] cable_gain_o
);

  // ****************************************
  // Fault flags
  // ****************************************
  logic [2:0] cond;
  logic [2:0] fault_flag;
  logic fault_read;
  logic [7:0] mask2_reg;
  logic [7:0] mask2_next;
  logic [7:0] mask0_reg;
  logic [7:0] mask0_next;

  // Thermal warning compares the live die temperature code to the threshold
  assign cond[2] = (die_temp_code_i >= ucs_pkg::THERMAL_WARN_CODE);
  assign cond[1] = input_ov_i;
  assign cond[0] = datapin_ov_i;
  assign fault_read = rd_i && (addr_i == ucs_pkg::FAULT_FLAGS_OFS);

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_flag
      // Read clear only takes effect when condition is absent
      ucs_flag u_flag (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .cond_i(cond[g]),
        .read_i(fault_read),
        .auto_clear_i(mask0_reg[ucs_pkg::AUTO_CLEAR_BIT]),
        .flag_o(fault_flag[g])
      );
    end
  endgenerate

  // ****************************************
  // Sample request sequencer
  // ****************************************
  ucs_pkg::ucs_state_t state_reg;
  ucs_pkg::ucs_state_t state_next;
  logic req_reg;
  logic req_next;
  logic done_reg;
  logic done_next;
  logic attach_ev_reg;
  logic attach_ev_next;
  logic attach_d_reg;
  logic attach_d_next;
  logic [7:0] curr_reg;
  logic [7:0] curr_next;
  logic [7:0] volt_reg;
  logic [7:0] volt_next;
  logic [7:0] temp_reg;
  logic [7:0] temp_next;
  logic event_read;
  logic sample_wr;

  assign event_read = rd_i && (addr_i == ucs_pkg::EVENT_FLAGS_OFS);
  assign sample_wr = wr_i && (addr_i == ucs_pkg::SAMPLE_REQ_OFS) && wdata_i[0];

  always_comb begin
    state_next = state_reg;
    req_next = req_reg;
    done_next = done_reg;
    curr_next = curr_reg;
    volt_next = volt_reg;
    temp_next = temp_reg;
    if (event_read) begin
      done_next = 1'b0;
    end
    unique case (state_reg)
      ucs_pkg::UCS_S_IDLE: begin
        if (sample_wr) begin
          req_next = 1'b1;
          state_next = ucs_pkg::UCS_S_CONV;
        end
      end
      ucs_pkg::UCS_S_CONV: begin
        if (conv_done_i) begin
          state_next = ucs_pkg::UCS_S_LOAD;
        end
      end
      ucs_pkg::UCS_S_LOAD: begin
        // Results update and done flag rises; request clears unless a new one lands
        curr_next = load_current_code_i;
        volt_next = port_voltage_code_i;
        temp_next = die_temp_code_i;
        done_next = 1'b1;
        // A request landing in the load cycle is not lost: it starts the next run
        if (sample_wr) begin
          req_next = 1'b1;
          state_next = ucs_pkg::UCS_S_CONV;
        end else begin
          req_next = 1'b0;
          state_next = ucs_pkg::UCS_S_IDLE;
        end
      end
      default: begin
        state_next = ucs_pkg::UCS_S_IDLE;
      end
    endcase
  end

  // Attach change event: set wins over read clear
  always_comb begin
    attach_d_next = attach_i;
    attach_ev_next = attach_ev_reg;
    if (attach_i != attach_d_reg) begin
      attach_ev_next = 1'b1;
    end else if (event_read) begin
      attach_ev_next = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= ucs_pkg::UCS_S_IDLE;
      req_reg <= 1'b0;
      done_reg <= 1'b0;
      curr_reg <= ucs_pkg::ZERO_BYTE;
      volt_reg <= ucs_pkg::ZERO_BYTE;
      temp_reg <= ucs_pkg::ZERO_BYTE;
      attach_ev_reg <= 1'b0;
      attach_d_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      req_reg <= req_next;
      done_reg <= done_next;
      curr_reg <= curr_next;
      volt_reg <= volt_next;
      temp_reg <= temp_next;
      attach_ev_reg <= attach_ev_next;
      attach_d_reg <= attach_d_next;
    end
  end

  assign conv_start_o = (state_reg == ucs_pkg::UCS_S_CONV);

  // ****************************************
  // Writable control registers
  // ****************************************
  logic [1:0] mode_reg;
  logic [1:0] mode_next;
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic cfg_wr_seen_reg;
  logic cfg_wr_seen_next;

  always_comb begin
    mask0_next = mask0_reg;
    mask2_next = mask2_reg;
    mode_next = mode_reg;
    cfg_next = cfg_reg;
    cfg_wr_seen_next = cfg_wr_seen_reg;
    if (wr_i) begin
      unique case (addr_i)
        ucs_pkg::MASK0_OFS: begin
          mask0_next = wdata_i & ucs_pkg::MASK0_BITS;
        end
        ucs_pkg::MASK2_OFS: begin
          mask2_next = wdata_i & ucs_pkg::FAULT_BITS;
        end
        ucs_pkg::SETUP3_OFS: begin
          mode_next = wdata_i[ucs_pkg::MODE_LSB +: 2];
        end
        ucs_pkg::CONFIG_SRC_OFS: begin
          cfg_next = wdata_i;
          cfg_wr_seen_next = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mask0_reg <= ucs_pkg::ZERO_BYTE;
      mask2_reg <= ucs_pkg::ZERO_BYTE;
      mode_reg <= 2'b00;
      cfg_reg <= ucs_pkg::ZERO_BYTE;
      cfg_wr_seen_reg <= 1'b0;
    end else begin
      mask0_reg <= mask0_next;
      mask2_reg <= mask2_next;
      mode_reg <= mode_next;
      cfg_reg <= cfg_next;
      cfg_wr_seen_reg <= cfg_wr_seen_next;
    end
  end

  // ****************************************
  // Configuration source selection
  // ****************************************
  // Standalone parts use resistors; otherwise register writes rule once made
  logic use_res;
  assign use_res = standalone_i || !cfg_wr_seen_reg;

  always_comb begin
    spread_spectrum_o = use_res ? first_config_resistor_i[7] : cfg_reg[7];
    sync_is_output_o = use_res ? first_config_resistor_i[6] : cfg_reg[6];
    freq_select_o = use_res ? first_config_resistor_i[2:0] : cfg_reg[2:0];
    current_limit_o = use_res ? third_config_resistor_i[2:0] : cfg_reg[5:3];
    // Gain combines second (upper bits) and third (low bits) resistors
    cable_gain_o = use_res ? {second_config_resistor_i[2:0], third_config_resistor_i[4:3]}
                           : {cfg_reg[2:0], cfg_reg[7:6]};
  end

  // Charger mode: data-mode pin low forces pass-through; auto-CDP goes
  // pass-through by itself once enumeration may begin
  always_comb begin
    if (!data_mode_pin_i) begin
      charger_mode_o = ucs_pkg::UCS_MODE_PASS;
    end else if ((mode_reg == ucs_pkg::UCS_MODE_CDP) && attach_i && enum_start_i) begin
      charger_mode_o = ucs_pkg::UCS_MODE_PASS;
    end else begin
      charger_mode_o = mode_reg;
    end
  end

  // ****************************************
  // Flag, event and status bytes
  // ****************************************
  logic [7:0] flags_byte;
  logic [7:0] events_byte;
  logic [7:0] status_byte;

  always_comb begin
    flags_byte = ucs_pkg::ZERO_BYTE;
    flags_byte[ucs_pkg::THERMAL_BIT] = fault_flag[2];
    flags_byte[ucs_pkg::INPUT_OV_BIT] = fault_flag[1];
    flags_byte[ucs_pkg::DATAPIN_OV_BIT] = fault_flag[0];
  end

  // Event byte: bit 3 is the live attach level, bits 0 and 1 clear on read
  always_comb begin
    events_byte = ucs_pkg::ZERO_BYTE;
    events_byte[ucs_pkg::SAMPLE_DONE_BIT] = done_reg;
    events_byte[1] = attach_ev_reg;
    events_byte[ucs_pkg::ATTACH_BIT] = attach_i;
  end

  always_comb begin
    status_byte = ucs_pkg::ZERO_BYTE;
    status_byte[ucs_pkg::ATTACH_BIT] = attach_i;
  end

  // ****************************************
  // Interrupt
  // ****************************************
  // Attach status and events are enabled from the low mask nibble
  logic fault_irq;
  logic event_irq;

  assign fault_irq = |(flags_byte & mask2_reg);
  assign event_irq = |(events_byte & {4'h0, mask0_reg[3:0]});
  assign irq_o = fault_irq || event_irq;

  // ****************************************
  // Read data
  // ****************************************
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  always_comb begin
    rdata_next = rdata_reg;
    if (rd_i) begin
      unique case (addr_i)
        ucs_pkg::FAULT_FLAGS_OFS: rdata_next = flags_byte;
        ucs_pkg::EVENT_FLAGS_OFS: rdata_next = events_byte;
        ucs_pkg::ATTACH_STATUS_OFS: rdata_next = status_byte;
        ucs_pkg::LOAD_CURRENT_OFS: rdata_next = curr_reg;
        ucs_pkg::PORT_VOLTAGE_OFS: rdata_next = volt_reg;
        ucs_pkg::DIE_TEMP_OFS: rdata_next = temp_reg;
        ucs_pkg::MASK0_OFS: rdata_next = mask0_reg;
        ucs_pkg::MASK2_OFS: rdata_next = mask2_reg;
        ucs_pkg::SAMPLE_REQ_OFS: rdata_next = {7'h00, req_reg};
        ucs_pkg::SETUP3_OFS: rdata_next = {2'b00, mode_reg, 4'h0};
        ucs_pkg::CONFIG_SRC_OFS: rdata_next = cfg_reg;
        default: rdata_next = ucs_pkg::ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_reg <= ucs_pkg::ZERO_BYTE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;
endmodule

// ==== sim/ucs_regs_checker.sv ====
// Purpose: Port checker for the charger register block
// Assumes: One clock, async active-low reset
// Notes: Bound to every ucs_regs instance
`timescale 1ns/1ns
module ucs_regs_checker (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic input_ov_i,
  input wire logic datapin_ov_i,
  input wire logic attach_i,
  input wire logic data_mode_pin_i,
  input wire logic conv_start_o,
  input wire logic [1:0] charger_mode_o
);
  // ****
  // Helpers
  // ****
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  wire rd_flags = rd_i && addr_i == ucs_pkg::FAULT_FLAGS_OFS;
  wire rd_attach = rd_i && addr_i == ucs_pkg::ATTACH_STATUS_OFS;
  wire req = wr_i && addr_i == ucs_pkg::SAMPLE_REQ_OFS && wdata_i[0];
  // Cleared flag must not come back while its condition stays low
  sequence two_clean_reads;
    (rd_flags && !input_ov_i) ##1 !input_ov_i ##1 (rd_flags && !input_ov_i);
  endsequence
  sequence ov_held_read;
    rd_flags && input_ov_i && $past(input_ov_i);
  endsequence
  sequence dp_held_read;
    rd_flags && datapin_ov_i && $past(datapin_ov_i);
  endsequence
  // ****
  // Properties
  // ****
  input_pin_overvoltage_flag_seen_a: assert property (ov_held_read |=> rdata_o[2])
    else $error("input overvoltage flag not read back");
  data_pin_overvoltage_flag_seen_a: assert property (dp_held_read |=> rdata_o[1])
    else $error("data pin flag not read back");
  clean_clear_a: assert property (two_clean_reads |=> !rdata_o[2])
    else $error("flag survived read after condition gone");
  flags_unused_a: assert property (rd_flags |=> rdata_o[7:4] == 4'h0 && !rdata_o[0])
    else $error("unused flag bits not zero");
  attach_live_a: assert property (rd_attach |=> rdata_o == {4'h0, $past(attach_i), 3'h0})
    else $error("attach status not live");
  unmapped_zero_a: assert property (rd_i && addr_i == 8'h20 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  sample_start_a: assert property (req |=> conv_start_o)
    else $error("sample request did not start conversion");
  start_cause_a: assert property ($rose(conv_start_o) |-> $past(req))
    else $error("conversion started without request");
  pass_forced_a: assert property (!data_mode_pin_i |-> charger_mode_o == 2'b00)
    else $error("low data-mode pin did not force pass-through");
endmodule
bind ucs_regs ucs_regs_checker u_chk (.mclk_i, .resetn_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .input_ov_i, .datapin_ov_i, .attach_i, .data_mode_pin_i,
  .conv_start_o, .charger_mode_o);

// ==== sim/ucs_host.sv ====
// Purpose: Register host model for the charger register block
// Assumes: Byte strobe port, read data one cycle after strobe
// Notes: Released lines show inverted values, never the last ones
`timescale 1ns/1ns
module ucs_host (
  input wire logic mclk_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i
);
  // ****
  // Bus cycles
  // ****
  initial begin
    {addr_o, wdata_o, wr_o, rd_o} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i) #2;
    {addr_o, wdata_o, wr_o} = {a, d, 1'b1};
    @(posedge mclk_i) #2;
    {addr_o, wdata_o, wr_o} = {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i) #2;
    {addr_o, rd_o} = {a, 1'b1};
    @(posedge mclk_i) #2;
    {addr_o, rd_o} = {~a, 1'b0};
    d = rdata_i;
  endtask
endmodule

// ==== sim/test_ucs_regs.sv ====
// Purpose: Self-checking bench for the charger register block
// Assumes: 25 MHz clock, host model drives the register port
// Notes: Resistor inputs held at fixed codes; config tested through resistors and registers
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module test_ucs_regs;
  logic mclk_i, resetn_i, wr_i, rd_i, input_ov_i, datapin_ov_i, attach_i;
  logic enum_start_i, data_mode_pin_i, standalone_i, conv_done_i, conv_start_o, irq_o;
  logic spread_spectrum_o, sync_is_output_o;
  logic [7:0] addr_i, wdata_i, rdata_o, lc, pv, dt, d, r1, r2, r3;
  logic [1:0] charger_mode_o;
  logic [2:0] freq_select_o, current_limit_o;
  logic [4:0] cable_gain_o;
  int bad_count, n_checks;
  ucs_regs u_ucs_regs (.mclk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .input_ov_i, .datapin_ov_i, .attach_i, .enum_start_i, .data_mode_pin_i,
    .standalone_i, .first_config_resistor_i(r1), .second_config_resistor_i(r2),
    .third_config_resistor_i(r3), .conv_done_i, .load_current_code_i(lc),
    .port_voltage_code_i(pv), .die_temp_code_i(dt), .conv_start_o, .irq_o,
    .charger_mode_o, .spread_spectrum_o, .sync_is_output_o, .freq_select_o,
    .current_limit_o, .cable_gain_o);
  ucs_host host (.mclk_i, .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i),
    .rdata_i(rdata_o));
  // ****
  // Tasks
  // ****
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d);
    `CHK(d, e)
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic t_reset;
    rd_chk(ucs_pkg::LOAD_CURRENT_OFS, 8'h00);
    rd_chk(ucs_pkg::PORT_VOLTAGE_OFS, 8'h00);
    rd_chk(ucs_pkg::DIE_TEMP_OFS, 8'h00);
    rd_chk(ucs_pkg::ATTACH_STATUS_OFS, 8'h00);
    rd_chk(8'h20, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_flags;
    {input_ov_i, datapin_ov_i} = 2'b11;
    repeat (2) @(posedge mclk_i);
    rd_chk(ucs_pkg::FAULT_FLAGS_OFS, 8'h06);
    rd_chk(ucs_pkg::FAULT_FLAGS_OFS, 8'h06);
    {input_ov_i, datapin_ov_i} = 2'b00;
    rd_chk(ucs_pkg::FAULT_FLAGS_OFS, 8'h06);
    rd_chk(ucs_pkg::FAULT_FLAGS_OFS, 8'h00);
    host.wr(ucs_pkg::MASK0_OFS, 8'h80);
    input_ov_i = 1'b1;
    rd_chk(ucs_pkg::FAULT_FLAGS_OFS, 8'h04);
    input_ov_i = 1'b0;
    repeat (3) @(posedge mclk_i);
    rd_chk(ucs_pkg::FAULT_FLAGS_OFS, 8'h00);
    host.wr(ucs_pkg::MASK0_OFS, 8'h00);
    $display("flag test done");
  endtask
  task automatic t_irq;
    input_ov_i = 1'b1;
    host.wr(ucs_pkg::MASK2_OFS, 8'h00);
    `CHK(irq_o, 1'b0)
    host.wr(ucs_pkg::MASK2_OFS, 8'h04);
    `CHK(irq_o, 1'b1)
    input_ov_i = 1'b0;
    rd_chk(ucs_pkg::FAULT_FLAGS_OFS, 8'h04);
    `CHK(irq_o, 1'b0)
    host.wr(ucs_pkg::MASK2_OFS, 8'h00);
    attach_i = 1'b1;
    rd_chk(ucs_pkg::ATTACH_STATUS_OFS, 8'h08);
    attach_i = 1'b0;
    rd_chk(ucs_pkg::ATTACH_STATUS_OFS, 8'h00);
    host.wr(ucs_pkg::MASK0_OFS, 8'h02);
    `CHK(irq_o, 1'b1)
    rd_chk(ucs_pkg::EVENT_FLAGS_OFS, 8'h02);
    `CHK(irq_o, 1'b0)
    host.wr(ucs_pkg::MASK0_OFS, 8'h00);
    $display("irq and attach test done");
  endtask
  task automatic t_mode;
    `CHK(spread_spectrum_o, 1'b0)
    `CHK(sync_is_output_o, 1'b1)
    `CHK(freq_select_o, 3'h5)
    `CHK(current_limit_o, 3'h2)
    `CHK(cable_gain_o, 5'h1A)
    host.wr(ucs_pkg::SETUP3_OFS, 8'h10);
    `CHK(charger_mode_o, 2'b00)
    data_mode_pin_i = 1'b1;
    for (int m = 0; m < 4; m++) begin
      host.wr(ucs_pkg::SETUP3_OFS, {2'b00, m[1:0], 4'h0});
      `CHK(charger_mode_o, m[1:0])
    end
    host.wr(ucs_pkg::SETUP3_OFS, 8'h10);
    attach_i = 1'b1;
    @(posedge mclk_i) #2;
    `CHK(charger_mode_o, 2'b01)
    enum_start_i = 1'b1;
    @(posedge mclk_i) #2;
    `CHK(charger_mode_o, 2'b00)
    {attach_i, enum_start_i} = 2'b00;
    host.wr(ucs_pkg::CONFIG_SRC_OFS, 8'hEB);
    `CHK(spread_spectrum_o, 1'b1)
    `CHK(sync_is_output_o, 1'b1)
    `CHK(freq_select_o, 3'h3)
    `CHK(current_limit_o, 3'h5)
    `CHK(cable_gain_o, 5'h0F)
    standalone_i = 1'b1;
    @(posedge mclk_i) #2;
    `CHK(freq_select_o, 3'h5)
    `CHK(cable_gain_o, 5'h1A)
    standalone_i = 1'b0;
    $display("mode and config test done");
  endtask
  task automatic t_sample;
    dt = 8'h76;
    host.wr(ucs_pkg::SAMPLE_REQ_OFS, 8'h01);
    `CHK(conv_start_o, 1'b1)
    repeat (2) @(posedge mclk_i) #2;
    conv_done_i = 1'b1;
    @(posedge mclk_i) #2;
    conv_done_i = 1'b0;
    repeat (3) @(posedge mclk_i);
    rd_chk(ucs_pkg::SAMPLE_REQ_OFS, 8'h00);
    host.rd(ucs_pkg::EVENT_FLAGS_OFS, d);
    `CHK(d[0], 1'b1)
    rd_chk(ucs_pkg::LOAD_CURRENT_OFS, 8'h5A);
    rd_chk(ucs_pkg::PORT_VOLTAGE_OFS, 8'hA5);
    rd_chk(ucs_pkg::DIE_TEMP_OFS, 8'h76);
    host.wr(ucs_pkg::LOAD_CURRENT_OFS, 8'hFF);
    rd_chk(ucs_pkg::LOAD_CURRENT_OFS, 8'h5A);
    host.rd(ucs_pkg::FAULT_FLAGS_OFS, d);
    `CHK(d[3], 1'b1)
    dt = 8'h75;
    rd_chk(ucs_pkg::FAULT_FLAGS_OFS, 8'h08);
    rd_chk(ucs_pkg::FAULT_FLAGS_OFS, 8'h00);
    $display("sample test done");
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
  initial begin
    {resetn_i, input_ov_i, datapin_ov_i, attach_i, enum_start_i} = '0;
    {data_mode_pin_i, standalone_i, conv_done_i} = '0;
    {lc, pv, dt} = {8'h5A, 8'hA5, 8'h10};
    {r1, r2, r3} = {8'h45, 8'h06, 8'h12};
    repeat (10) @(posedge mclk_i);
    #2 resetn_i = 1'b1;
    t_reset();
    t_flags();
    t_irq();
    t_mode();
    t_sample();
    stop_test();
  end
endmodule
